/* dff_read_port.sv */
// Read port and flag logic of two independent 9-bit FIFO banks.
// Assumes all bank pins are asynchronous to CORE_CLK.
//
// Contract
// - Each bank drives its own 9-bit read data bus.
// - Both read enables low reads one word per read clock rise.
// - A read while the empty flag is low is ignored.
// - Output enable low drives data pins; high releases them.
// - Empty flag low when no word stored, high otherwise.
// - Empty flag changes only at read clock rises.
// - Almost-empty flag low when count within offset; offset resets to 7.
// - Almost-empty flag changes only at read clock rises.
// - Almost-full flag low when free space within offset; resets to 7.
// - Almost-full flag changes only at write clock rises.
// - Full flag low when every location used, high otherwise.
// - Full flag changes only at write clock rises.
// - Bank reset zeroes pointers, full flags high, empty flags low.
// - First write enable low writes on write clock rise unless full.
// - Dual-purpose pin sampled at reset picks write enable or offset load.
`timescale 1ns/1ps
module dff_read_port #(
  parameter int DEPTH = dff_pkg::DEPTH
) (
  // Core clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RSTN,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic             PREADY,
  output logic [31:0]      PRDATA,
  output logic             PSLVERR,
  output logic             IRQ,
  // Bank A pins
  input  wire logic        BANK_RESET_A_N,
  input  wire logic        WRITE_CLOCK_BANK_A,
  input  wire logic        WRITE_ENABLE_FIRST_BANK_A_N,
  input  wire logic        SECOND_WRITE_ENABLE_OR_OFFSET_LOAD_A,
  input  wire logic [8:0]  WRITE_DATA_BANK_A,
  input  wire logic        READ_CLOCK_BANK_A,
  input  wire logic        READ_ENABLE_FIRST_BANK_A_N,
  input  wire logic        READ_ENABLE_SECOND_BANK_A_N,
  input  wire logic        OUTPUT_DRIVE_ENABLE_A_N,
  output logic [8:0]       READ_DATA_BANK_A,
  output logic             READ_DATA_BANK_A_OE,
  output logic             EMPTY_FLAG_A_N,
  output logic             ALMOST_EMPTY_FLAG_A_N,
  output logic             ALMOST_FULL_FLAG_A_N,
  output logic             FULL_FLAG_A_N,
  // Bank B pins
  input  wire logic        BANK_RESET_B_N,
  input  wire logic        WRITE_CLOCK_BANK_B,
  input  wire logic        WRITE_ENABLE_FIRST_BANK_B_N,
  input  wire logic        SECOND_WRITE_ENABLE_OR_OFFSET_LOAD_B,
  input  wire logic [8:0]  WRITE_DATA_BANK_B,
  input  wire logic        READ_CLOCK_BANK_B,
  input  wire logic        READ_ENABLE_FIRST_BANK_B_N,
  input  wire logic        READ_ENABLE_SECOND_BANK_B_N,
  input  wire logic        OUTPUT_DRIVE_ENABLE_B_N,
  output logic [8:0]       READ_DATA_BANK_B,
  output logic             READ_DATA_BANK_B_OE,
  output logic             EMPTY_FLAG_B_N,
  output logic             ALMOST_EMPTY_FLAG_B_N,
  output logic             ALMOST_FULL_FLAG_B_N,
  output logic             FULL_FLAG_B_N
);
  localparam int NB = dff_pkg::NUM_BANKS;
  localparam int DW = dff_pkg::DATA_W;
  localparam int SW = dff_pkg::SYNC_W;
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam int EW = NB * dff_pkg::EV_PER_BANK;
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

  // ------
  // Pin packing
  // ------
  logic [NB-1:0][SW-1:0] raw;
  logic [NB-1:0][DW-1:0] q;
  logic [NB-1:0]         q_oe;
  logic [NB-1:0]         ef_n;
  logic [NB-1:0]         pae_n;
  logic [NB-1:0]         paf_n;
  logic [NB-1:0]         ff_n;
  logic [NB-1:0]         two_wen;
  logic [NB-1:0][CW-1:0] count;
  logic [NB-1:0][CW-1:0] ae_ofs;
  logic [NB-1:0][CW-1:0] af_ofs;
  logic [NB-1:0][dff_pkg::EV_PER_BANK-1:0] evt;

  assign raw[0] = {WRITE_DATA_BANK_A, OUTPUT_DRIVE_ENABLE_A_N,
                   READ_ENABLE_SECOND_BANK_A_N,
                   READ_ENABLE_FIRST_BANK_A_N, READ_CLOCK_BANK_A,
                   SECOND_WRITE_ENABLE_OR_OFFSET_LOAD_A,
                   WRITE_ENABLE_FIRST_BANK_A_N, WRITE_CLOCK_BANK_A,
                   BANK_RESET_A_N};
  assign raw[1] = {WRITE_DATA_BANK_B, OUTPUT_DRIVE_ENABLE_B_N,
                   READ_ENABLE_SECOND_BANK_B_N,
                   READ_ENABLE_FIRST_BANK_B_N, READ_CLOCK_BANK_B,
                   SECOND_WRITE_ENABLE_OR_OFFSET_LOAD_B,
                   WRITE_ENABLE_FIRST_BANK_B_N, WRITE_CLOCK_BANK_B,
                   BANK_RESET_B_N};

  assign READ_DATA_BANK_A      = q[0];
  assign READ_DATA_BANK_B      = q[1];
  assign READ_DATA_BANK_A_OE   = q_oe[0];
  assign READ_DATA_BANK_B_OE   = q_oe[1];
  assign EMPTY_FLAG_A_N        = ef_n[0];
  assign EMPTY_FLAG_B_N        = ef_n[1];
  assign ALMOST_EMPTY_FLAG_A_N = pae_n[0];
  assign ALMOST_EMPTY_FLAG_B_N = pae_n[1];
  assign ALMOST_FULL_FLAG_A_N  = paf_n[0];
  assign ALMOST_FULL_FLAG_B_N  = paf_n[1];
  assign FULL_FLAG_A_N         = ff_n[0];
  assign FULL_FLAG_B_N         = ff_n[1];

  // ------
  // APB decode
  // ------
  logic apb_wr;
  logic mapped;

  assign PREADY = 1'b1;
  assign apb_wr = PSEL & PENABLE & PWRITE & mapped;

  // ------
  // Banks
  // ------
  for (genvar b = 0; b < NB; b++) begin : g_bank
    localparam logic [7:0] AE_ADDR = dff_pkg::OFS_AE_OFFSET
                                   + 8'(b) * dff_pkg::OFS_BANK_STRIDE;
    localparam logic [7:0] AF_ADDR = dff_pkg::OFS_AF_OFFSET
                                   + 8'(b) * dff_pkg::OFS_BANK_STRIDE;
    logic [SW-1:0] s;
    logic          rclk_q;
    logic          wclk_q;
    logic          rclk_rise;
    logic          wclk_rise;
    logic          bank_rst;
    logic          wr_ok;
    logic          rd_ok;
    logic          ld_op;
    logic          ld_sel;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] next_count;
    logic          next_ae_n;
    logic          next_af_n;

    dff_sync #(.WIDTH(SW)) u_sync (
      .clk   (CORE_CLK),
      .din   (raw[b]),
      .dout  (s)
    );

    always_ff @(posedge CORE_CLK) begin
      rclk_q <= s[dff_pkg::SB_RCLK];
      wclk_q <= s[dff_pkg::SB_WCLK];
    end

    assign rclk_rise = s[dff_pkg::SB_RCLK] & ~rclk_q;
    assign wclk_rise = s[dff_pkg::SB_WCLK] & ~wclk_q;
    assign bank_rst  = ~RSTN | ~s[dff_pkg::SB_RST];

    // Strap follows the pin all through reset, frozen at release
    always_ff @(posedge CORE_CLK) begin
      if (bank_rst) begin
        two_wen[b] <= s[dff_pkg::SB_WEN2];
      end
    end

    // A low second pin means an offset load in load mode and a
    // blocked write in two-enable mode, so one write term serves both
    assign wr_ok = wclk_rise & ~s[dff_pkg::SB_WEN1]
                 & s[dff_pkg::SB_WEN2] & ff_n[b];
    assign ld_op = wclk_rise & ~s[dff_pkg::SB_WEN1]
                 & ~s[dff_pkg::SB_WEN2] & ~two_wen[b];
    assign rd_ok = rclk_rise & ~s[dff_pkg::SB_REN1]
                 & ~s[dff_pkg::SB_REN2] & ef_n[b];

    assign next_count = count[b] + CW'(wr_ok) - CW'(rd_ok);
    assign next_ae_n  = next_count > ae_ofs[b];
    assign next_af_n  = next_count < (FULL_COUNT - af_ofs[b]);

    always_ff @(posedge CORE_CLK) begin
      if (bank_rst) begin
        wp       <= '0;
        rp       <= '0;
        count[b] <= '0;
      end else begin
        wp       <= wp + AW'(wr_ok);
        rp       <= rp + AW'(rd_ok);
        count[b] <= next_count;
      end
    end

    // Empty side flags move on read clock rises only
    always_ff @(posedge CORE_CLK) begin
      if (bank_rst) begin
        ef_n[b]  <= 1'b0;
        pae_n[b] <= 1'b0;
      end else if (rclk_rise) begin
        ef_n[b]  <= next_count != '0;
        pae_n[b] <= next_ae_n;
      end
    end

    // Full side flags move on write clock rises only
    always_ff @(posedge CORE_CLK) begin
      if (bank_rst) begin
        ff_n[b]  <= 1'b1;
        paf_n[b] <= 1'b1;
      end else if (wclk_rise) begin
        ff_n[b]  <= next_count != FULL_COUNT;
        paf_n[b] <= next_af_n;
      end
    end

    // Pin loads alternate empty offset then full offset
    always_ff @(posedge CORE_CLK) begin
      if (bank_rst) begin
        ae_ofs[b] <= CW'(dff_pkg::RST_AE_OFFSET);
        af_ofs[b] <= CW'(dff_pkg::RST_AF_OFFSET);
        ld_sel    <= 1'b0;
      end else begin
        if (ld_op) begin
          ld_sel <= ~ld_sel;
        end
        if (ld_op && !ld_sel) begin
          ae_ofs[b] <= CW'(s[dff_pkg::SB_WDATA +: DW]);
        end else if (apb_wr && PADDR == AE_ADDR) begin
          ae_ofs[b] <= PWDATA[CW-1:0];
        end
        if (ld_op && ld_sel) begin
          af_ofs[b] <= CW'(s[dff_pkg::SB_WDATA +: DW]);
        end else if (apb_wr && PADDR == AF_ADDR) begin
          af_ofs[b] <= PWDATA[CW-1:0];
        end
      end
    end

    assign evt[b][dff_pkg::EV_EMPTY]  = ~bank_rst & rclk_rise & ef_n[b]
                                      & (next_count == '0);
    assign evt[b][dff_pkg::EV_AEMPTY] = ~bank_rst & rclk_rise & pae_n[b]
                                      & ~next_ae_n;
    assign evt[b][dff_pkg::EV_AFULL]  = ~bank_rst & wclk_rise & paf_n[b]
                                      & ~next_af_n;
    assign evt[b][dff_pkg::EV_FULL]   = ~bank_rst & wclk_rise & ff_n[b]
                                      & (next_count == FULL_COUNT);

    dff_mem_if #(.AW(AW), .DW(DW)) mif ();

    assign mif.wr_en   = wr_ok;
    assign mif.wr_addr = wp;
    assign mif.wr_data = s[dff_pkg::SB_WDATA +: DW];
    assign mif.rd_en   = rd_ok;
    assign mif.rd_addr = rp;
    assign q[b]        = mif.rd_data;
    assign q_oe[b]     = ~s[dff_pkg::SB_OE];

    dff_mem #(.AW(AW), .DW(DW)) u_mem (
      .clk   (CORE_CLK),
      .rst_n (RSTN),
      .port  (mif.mem)
    );
  end

  // ------
  // Interrupts
  // ------
  logic [EW-1:0] irq_status;
  logic [EW-1:0] irq_mask;
  logic [EW-1:0] irq_clr;

  assign irq_clr = (apb_wr && PADDR == dff_pkg::OFS_IRQ_STATUS)
                 ? PWDATA[EW-1:0] : '0;

  // Set beats a clear landing in the same cycle
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | evt;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      irq_mask <= dff_pkg::RST_IRQ_MASK;
    end else if (apb_wr && PADDR == dff_pkg::OFS_IRQ_MASK) begin
      irq_mask <= PWDATA[EW-1:0];
    end
  end

  assign IRQ = |(irq_status & irq_mask);

  // ------
  // Read mux, captured in the setup phase for a zero-wait answer
  // ------
  logic [31:0] rd_val;

  always_comb begin
    rd_val = '0;
    mapped = 1'b1;
    unique case (PADDR)
      dff_pkg::OFS_AE_OFFSET: rd_val[CW-1:0] = ae_ofs[0];
      dff_pkg::OFS_AF_OFFSET: rd_val[CW-1:0] = af_ofs[0];
      dff_pkg::OFS_AE_OFFSET + dff_pkg::OFS_BANK_STRIDE:
        rd_val[CW-1:0] = ae_ofs[1];
      dff_pkg::OFS_AF_OFFSET + dff_pkg::OFS_BANK_STRIDE:
        rd_val[CW-1:0] = af_ofs[1];
      dff_pkg::OFS_FLAGS: begin
        for (int i = 0; i < NB; i++) begin
          rd_val[i*dff_pkg::FLAG_BANK_SHIFT + dff_pkg::FLAG_EMPTY]
            = ef_n[i];
          rd_val[i*dff_pkg::FLAG_BANK_SHIFT + dff_pkg::FLAG_AEMPTY]
            = pae_n[i];
          rd_val[i*dff_pkg::FLAG_BANK_SHIFT + dff_pkg::FLAG_AFULL]
            = paf_n[i];
          rd_val[i*dff_pkg::FLAG_BANK_SHIFT + dff_pkg::FLAG_FULL]
            = ff_n[i];
          rd_val[i*dff_pkg::FLAG_BANK_SHIFT + dff_pkg::FLAG_TWO_WEN]
            = two_wen[i];
        end
      end
      dff_pkg::OFS_COUNT: begin
        for (int i = 0; i < NB; i++) begin
          rd_val[i*dff_pkg::COUNT_SHIFT +: CW] = count[i];
        end
      end
      dff_pkg::OFS_IRQ_STATUS: rd_val[EW-1:0] = irq_status;
      dff_pkg::OFS_IRQ_MASK:   rd_val[EW-1:0] = irq_mask;
      default:                 mapped = 1'b0;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      PRDATA  <= '0;
      PSLVERR <= 1'b0;
    end else if (PSEL && !PENABLE) begin
      PRDATA  <= PWRITE ? 32'h0000_0000 : rd_val;
      PSLVERR <= ~mapped;
    end
  end
endmodule

/* dff_pkg.sv */
// Shared constants of the dual FIFO read port and flag block.
// Assumes a 32-bit APB slave at byte offsets below and 9-bit banks.
package dff_pkg;

  // ------
  // Sizes
  // ------
  localparam int DATA_W    = 9;
  localparam int DEPTH     = 256;
  localparam int NUM_BANKS = 2;

  // ------
  // Register map (byte offsets)
  // ------
  localparam logic [7:0] OFS_AE_OFFSET   = 8'h00;
  localparam logic [7:0] OFS_AF_OFFSET   = 8'h04;
  localparam logic [7:0] OFS_BANK_STRIDE = 8'h08;
  localparam logic [7:0] OFS_FLAGS       = 8'h10;
  localparam logic [7:0] OFS_COUNT       = 8'h14;
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK    = 8'h1C;

  // ------
  // Field layouts and reset values
  // ------
  localparam int RST_AE_OFFSET   = 7;
  localparam int RST_AF_OFFSET   = 7;
  localparam int FLAG_BANK_SHIFT = 8;
  localparam int FLAG_EMPTY      = 0;
  localparam int FLAG_AEMPTY     = 1;
  localparam int FLAG_AFULL      = 2;
  localparam int FLAG_FULL       = 3;
  localparam int FLAG_TWO_WEN    = 4;
  localparam int COUNT_SHIFT     = 16;
  localparam int EV_PER_BANK     = 4;
  localparam int EV_EMPTY        = 0;
  localparam int EV_AEMPTY       = 1;
  localparam int EV_AFULL        = 2;
  localparam int EV_FULL         = 3;
  localparam logic [7:0] RST_IRQ_MASK = 8'h00;

  // ------
  // Positions in the synchronised pin vector of one bank
  // ------
  localparam int SB_RST   = 0;
  localparam int SB_WCLK  = 1;
  localparam int SB_WEN1  = 2;
  localparam int SB_WEN2  = 3;
  localparam int SB_RCLK  = 4;
  localparam int SB_REN1  = 5;
  localparam int SB_REN2  = 6;
  localparam int SB_OE    = 7;
  localparam int SB_WDATA = 8;
  localparam int SYNC_W   = SB_WDATA + DATA_W;

endpackage

/* dff_mem_if.sv */
// Storage port between a bank's control logic and its memory.
// Assumes one clock domain on both sides.
`timescale 1ns/1ps
interface dff_mem_if #(
  parameter int AW = 8,
  parameter int DW = 9
);
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic          rd_en;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;

  modport ctrl (output wr_en, wr_addr, wr_data, rd_en, rd_addr,
                input  rd_data);
  modport mem  (input  wr_en, wr_addr, wr_data, rd_en, rd_addr,
                output rd_data);
endinterface

/* dff_sync.sv */
// Two-flop synchroniser for a vector of independent pin levels.
// Assumes each bit is a level held over several core clocks.
`timescale 1ns/1ps
module dff_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta;

  // No reset: pins read true while the core resets
  always_ff @(posedge clk) begin
    meta <= din;
    dout <= meta;
  end
endmodule

/* dff_mem.sv */
// Storage array of one bank with a registered read port.
// Assumes the controller never reads and writes one word at once.
`timescale 1ns/1ps
module dff_mem #(
  parameter int AW = 8,
  parameter int DW = 9
) (
  input  wire logic clk,
  input  wire logic rst_n,
  dff_mem_if.mem    port
);
  logic [DW-1:0] store [2**AW];

  always_ff @(posedge clk) begin
    if (port.wr_en) begin
      store[port.wr_addr] <= port.wr_data;
    end
  end

  // Read register holds the last word between reads
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      port.rd_data <= '0;
    end else if (port.rd_en) begin
      port.rd_data <= store[port.rd_addr];
    end
  end
endmodule

/* dff_read_port_properties.sv */
// Concurrent checks on the bank A pins of the dual FIFO read port.
// Assumes bank A link clocks are much slower than CORE_CLK.
`timescale 1ns/1ps
module dff_read_port_properties #(
  parameter int DEPTH = dff_pkg::DEPTH
) (
  // Core
  input wire logic       CORE_CLK,
  input wire logic       RSTN,
  input wire logic       IRQ,
  // Bank A
  input wire logic       BANK_RESET_A_N,
  input wire logic       WRITE_CLOCK_BANK_A,
  input wire logic       READ_CLOCK_BANK_A,
  input wire logic       OUTPUT_DRIVE_ENABLE_A_N,
  input wire logic [8:0] READ_DATA_BANK_A,
  input wire logic       READ_DATA_BANK_A_OE,
  input wire logic       EMPTY_FLAG_A_N,
  input wire logic       ALMOST_EMPTY_FLAG_A_N,
  input wire logic       ALMOST_FULL_FLAG_A_N,
  input wire logic       FULL_FLAG_A_N
);
  // ------
  // Raw pin history: a flag may move only a few cycles after a rise
  // ------
  logic [7:0] rck_h;
  logic [7:0] wck_h;
  logic [3:0] brs_h;
  logic       rck_new;
  logic       wck_new;
  logic       bank_ok;
  always_ff @(posedge CORE_CLK) rck_h <= {rck_h[6:0], READ_CLOCK_BANK_A};
  always_ff @(posedge CORE_CLK) wck_h <= {wck_h[6:0], WRITE_CLOCK_BANK_A};
  always_ff @(posedge CORE_CLK) brs_h <= {brs_h[2:0], BANK_RESET_A_N};
  assign rck_new = |(rck_h[6:1] & ~rck_h[7:2]);
  assign wck_new = |(wck_h[6:1] & ~wck_h[7:2]);
  // Bank reset moves the four flags with no clock
  assign bank_ok = BANK_RESET_A_N & (&brs_h);

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  oe_on_a: assert property (
    (!OUTPUT_DRIVE_ENABLE_A_N) [*5] |-> READ_DATA_BANK_A_OE)
    else $error("Data pins not driven with output enable low");
  oe_off_a: assert property (
    OUTPUT_DRIVE_ENABLE_A_N [*5] |-> !READ_DATA_BANK_A_OE)
    else $error("Data pins driven with output enable high");
  ef_timing_a: assert property (
    bank_ok && ($changed(EMPTY_FLAG_A_N) || $changed(ALMOST_EMPTY_FLAG_A_N))
    |-> rck_new) else $error("Empty side flag moved off a read clock rise");
  ff_timing_a: assert property (
    bank_ok && ($changed(FULL_FLAG_A_N) || $changed(ALMOST_FULL_FLAG_A_N))
    |-> wck_new) else $error("Full side flag moved off a write clock rise");
  full_af_a: assert property (
    !FULL_FLAG_A_N |-> !ALMOST_FULL_FLAG_A_N)
    else $error("Full without almost full");
  empty_ae_a: assert property (
    !EMPTY_FLAG_A_N |-> !ALMOST_EMPTY_FLAG_A_N)
    else $error("Empty without almost empty");
  bank_rst_a: assert property (
    (!BANK_RESET_A_N) [*5] |-> FULL_FLAG_A_N && ALMOST_FULL_FLAG_A_N &&
    !EMPTY_FLAG_A_N && !ALMOST_EMPTY_FLAG_A_N)
    else $error("Flags wrong during bank reset");
  data_hold_a: assert property (
    bank_ok && $changed(READ_DATA_BANK_A) |-> rck_new)
    else $error("Read data moved without a read clock rise");
  empty_refuse_a: assert property (
    bank_ok && !EMPTY_FLAG_A_N |=> $stable(READ_DATA_BANK_A))
    else $error("Read accepted while empty");

  cover property (!FULL_FLAG_A_N);
  cover property (bank_ok && !EMPTY_FLAG_A_N && $rose(READ_CLOCK_BANK_A));
  cover property ($rose(IRQ));
endmodule

bind dff_read_port dff_read_port_properties #(.DEPTH(DEPTH)) u_props (
  .CORE_CLK(CORE_CLK), .RSTN(RSTN), .IRQ(IRQ),
  .BANK_RESET_A_N(BANK_RESET_A_N), .WRITE_CLOCK_BANK_A(WRITE_CLOCK_BANK_A),
  .READ_CLOCK_BANK_A(READ_CLOCK_BANK_A),
  .OUTPUT_DRIVE_ENABLE_A_N(OUTPUT_DRIVE_ENABLE_A_N),
  .READ_DATA_BANK_A(READ_DATA_BANK_A),
  .READ_DATA_BANK_A_OE(READ_DATA_BANK_A_OE),
  .EMPTY_FLAG_A_N(EMPTY_FLAG_A_N),
  .ALMOST_EMPTY_FLAG_A_N(ALMOST_EMPTY_FLAG_A_N),
  .ALMOST_FULL_FLAG_A_N(ALMOST_FULL_FLAG_A_N),
  .FULL_FLAG_A_N(FULL_FLAG_A_N)
);

/* dff_reader_model.sv */
// Downstream reader at the read port of one bank.
// Assumes the bench raises n_req by the number of reads it wants.
`timescale 1ns/1ps
module dff_reader_model #(
  parameter realtime PHASE = 5.3
) (
  // Design side
  input  wire logic [8:0] data,
  input  wire logic       data_oe,
  input  wire logic       empty_n,
  output logic            rclk,
  output logic            ren1_n,
  output logic            ren2_n,
  output logic            oe_n,
  output wire logic [8:0] q,
  // Bench side
  input  wire logic [7:0] n_req,
  input  wire logic       oe_req,
  output logic      [8:0] got,
  output int              n_got
);
  logic [7:0] issued;
  logic       pend;
  // ------
  // Free running read clock, 32 ns
  // ------
  initial begin
    rclk = 1'b0;
    issued = 8'h00;
    pend = 1'b0;
    got = 9'h000;
    n_got = 0;
    ren1_n = 1'b1;
    ren2_n = 1'b1;
    oe_n = 1'b0;
    #(PHASE);
    forever #16 rclk = ~rclk;
  end
  // Enables move half a period ahead of the sampling rise
  always @(negedge rclk) begin
    ren1_n <= (issued == n_req);
    ren2_n <= (issued == n_req);
    if (issued != n_req) issued <= issued + 8'h01;
    oe_n <= ~oe_req;
  end
  // A word read at one rise is settled by the next one
  always @(posedge rclk) begin
    pend <= ~ren1_n & ~ren2_n & empty_n;
    if (pend) got <= q;
    if (pend) n_got <= n_got + 1;
  end
  assign q = data_oe ? data : {9{1'bz}};
endmodule

/* fifo_read_port_and_flags_tb_top.sv */
// Self-checking bench of the dual FIFO read port and flag block.
// Assumes the reader model and the bound checker beside it.
`timescale 1ns/1ps
module fifo_read_port_and_flags_tb_top;
  localparam int DEPTH = 16;
  logic        core_clk, rstn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        brst_n [2], wclk [2], wen_n [2], wen2 [2], rclk [2];
  logic        ren1_n [2], ren2_n [2], oe_n [2], d_oe [2], oe_req [2];
  logic        ef_n [2], ae_n [2], af_n [2], ff_n [2];
  logic [8:0]  wdat [2], rdat [2], got [2];
  logic [7:0]  n_req [2];
  wire  [8:0]  q_a, q_b;
  int          n_got [2];
  int          mismatches, n_checks, cyc;

  dff_read_port #(.DEPTH(DEPTH)) DUT (
    .CORE_CLK(core_clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready),
    .PRDATA(prdata), .PSLVERR(pslverr), .IRQ(irq),
    .BANK_RESET_A_N(brst_n[0]), .WRITE_CLOCK_BANK_A(wclk[0]),
    .WRITE_ENABLE_FIRST_BANK_A_N(wen_n[0]),
    .SECOND_WRITE_ENABLE_OR_OFFSET_LOAD_A(wen2[0]),
    .WRITE_DATA_BANK_A(wdat[0]), .READ_CLOCK_BANK_A(rclk[0]),
    .READ_ENABLE_FIRST_BANK_A_N(ren1_n[0]),
    .READ_ENABLE_SECOND_BANK_A_N(ren2_n[0]),
    .OUTPUT_DRIVE_ENABLE_A_N(oe_n[0]), .READ_DATA_BANK_A(rdat[0]),
    .READ_DATA_BANK_A_OE(d_oe[0]), .EMPTY_FLAG_A_N(ef_n[0]),
    .ALMOST_EMPTY_FLAG_A_N(ae_n[0]), .ALMOST_FULL_FLAG_A_N(af_n[0]),
    .FULL_FLAG_A_N(ff_n[0]),
    .BANK_RESET_B_N(brst_n[1]), .WRITE_CLOCK_BANK_B(wclk[1]),
    .WRITE_ENABLE_FIRST_BANK_B_N(wen_n[1]),
    .SECOND_WRITE_ENABLE_OR_OFFSET_LOAD_B(wen2[1]),
    .WRITE_DATA_BANK_B(wdat[1]), .READ_CLOCK_BANK_B(rclk[1]),
    .READ_ENABLE_FIRST_BANK_B_N(ren1_n[1]),
    .READ_ENABLE_SECOND_BANK_B_N(ren2_n[1]),
    .OUTPUT_DRIVE_ENABLE_B_N(oe_n[1]), .READ_DATA_BANK_B(rdat[1]),
    .READ_DATA_BANK_B_OE(d_oe[1]), .EMPTY_FLAG_B_N(ef_n[1]),
    .ALMOST_EMPTY_FLAG_B_N(ae_n[1]), .ALMOST_FULL_FLAG_B_N(af_n[1]),
    .FULL_FLAG_B_N(ff_n[1]));

  dff_reader_model #(.PHASE(5.3)) RD_A (.data(rdat[0]), .data_oe(d_oe[0]),
    .empty_n(ef_n[0]), .rclk(rclk[0]), .ren1_n(ren1_n[0]),
    .ren2_n(ren2_n[0]), .oe_n(oe_n[0]), .q(q_a), .n_req(n_req[0]),
    .oe_req(oe_req[0]), .got(got[0]), .n_got(n_got[0]));
  dff_reader_model #(.PHASE(9.1)) RD_B (.data(rdat[1]), .data_oe(d_oe[1]),
    .empty_n(ef_n[1]), .rclk(rclk[1]), .ren1_n(ren1_n[1]),
    .ren2_n(ren2_n[1]), .oe_n(oe_n[1]), .q(q_b), .n_req(n_req[1]),
    .oe_req(oe_req[1]), .got(got[1]), .n_got(n_got[1]));

  // ------
  // Clocks and hang guard
  // ------
  always #2 core_clk = ~core_clk;
  initial begin
    wclk = '{1'b0, 1'b0};
    #7.7;
    forever begin
      #16;
      wclk[0] = ~wclk[0];
      wclk[1] = ~wclk[1];
    end
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches = mismatches + 1;
      print_verdict();
    end
  end

  // ------
  // Shared tasks
  // ------
  task automatic print_verdict;
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, r, exp);
  endtask
  // Both banks share one write clock
  task automatic wr(input int b, input int n, input logic [8:0] base);
    for (int i = 0; i < n; i++) begin
      @(negedge wclk[0]);
      @(posedge core_clk);
      wen_n[b] <= 1'b0;
      wdat[b] <= base + 9'(i);
    end
    @(negedge wclk[0]);
    @(posedge core_clk);
    wen_n[b] <= 1'b1;
  endtask
  task automatic rd(input int b, input int n, input logic [8:0] base);
    int tgt;
    tgt = n_got[b];
    @(posedge core_clk);
    n_req[b] <= n_req[b] + 8'(n);
    for (int i = 0; i < n; i++) begin
      for (int k = 0; k < 100 && n_got[b] == tgt + i; k++)
        @(posedge core_clk);
      chk("read word", got[b], base + 9'(i));
    end
  endtask
  task automatic settle;
    repeat (40) @(posedge core_clk);
  endtask
  task automatic brst(input int b);
    @(posedge core_clk);
    brst_n[b] <= 1'b0;
    repeat (8) @(posedge core_clk);
    brst_n[b] <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask

  // ------
  // Scenarios
  // ------
  task automatic t_reset;
    logic [31:0] r;
    logic        e;
    rchk("flags", 8'h10, 32'h0000_1C1C);
    rchk("ae offset a", 8'h00, 32'h7);
    rchk("af offset b", 8'h0C, 32'h7);
    rchk("mask", 8'h1C, 32'h0);
    apb(1'b0, 8'h20, 32'h0, r, e);
    chk("unmapped", {r[30:0], e}, 32'h1);
    chk("pins", {ef_n[0], ae_n[0], af_n[0], ff_n[0]}, 4'h3);
  endtask
  task automatic t_fill;
    wr(0, 7, 9'h100);
    settle();
    chk("count 7", {ef_n[0], ae_n[0], af_n[0]}, 3'h5);
    wr(0, 1, 9'h107);
    settle();
    chk("count 8", {ae_n[0], af_n[0]}, 2'h3);
    wr(0, 1, 9'h108);
    settle();
    chk("count 9", {af_n[0], ff_n[0]}, 2'h1);
    wr(0, 8, 9'h109);
    settle();
    chk("full", ff_n[0], 1'b0);
    rchk("count", 8'h14, 32'(DEPTH));
    chk("bank b", ef_n[1], 1'b0);
  endtask
  task automatic t_drain;
    rd(0, DEPTH, 9'h100);
    settle();
    chk("drained", {ef_n[0], ae_n[0], ff_n[0]}, 3'h1);
    @(posedge core_clk);
    n_req[0] <= n_req[0] + 8'h01;
    settle();
    rchk("empty read", 8'h14, 32'h0);
    chk("held data", q_a, 9'h10F);
  endtask
  task automatic t_oe;
    @(posedge core_clk);
    oe_req[0] <= 1'b0;
    settle();
    chk("released", q_a, {9{1'bz}});
    oe_req[0] <= 1'b1;
    settle();
    chk("driven", q_a, 9'h10F);
  endtask
  task automatic t_irq;
    logic [31:0] r;
    logic        e;
    rchk("status", 8'h18, 32'hF);
    chk("masked", irq, 1'b0);
    apb(1'b1, 8'h1C, 32'h1, r, e);
    @(posedge core_clk);
    chk("unmasked", irq, 1'b1);
    apb(1'b1, 8'h18, 32'hF, r, e);
    @(posedge core_clk);
    chk("cleared", irq, 1'b0);
    rchk("status clear", 8'h18, 32'h0);
  endtask
  task automatic t_bank_b;
    @(posedge core_clk);
    wen2[1] <= 1'b0;
    brst(1);
    rchk("load mode", 8'h10, 32'h0000_0C1C);
    wr(1, 1, 9'h003);
    rchk("loaded", 8'h08, 32'h3);
    rchk("no write", 8'h14, 32'h0);
    rchk("a offset", 8'h00, 32'h7);
    wen2[1] <= 1'b1;
    brst(1);
    wr(1, 2, 9'h0AA);
    settle();
    rd(1, 2, 9'h0AA);
    chk("a untouched", q_a, 9'h10F);
  endtask
  task automatic t_bank_reset;
    wr(0, 3, 9'h055);
    settle();
    chk("filled", ef_n[0], 1'b1);
    brst(0);
    chk("reset", {ef_n[0], ae_n[0], af_n[0], ff_n[0]}, 4'h3);
    rchk("reset count", 8'h14, 32'h0);
  endtask

  initial begin
    core_clk = 1'b0;
    rstn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    brst_n = '{1'b1, 1'b1};
    wen_n = '{1'b1, 1'b1};
    wen2 = '{1'b1, 1'b1};
    oe_req = '{1'b1, 1'b1};
    wdat = '{9'h000, 9'h000};
    n_req = '{8'h00, 8'h00};
    mismatches = 0;
    n_checks = 0;
    cyc = 0;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_reset();
    t_fill();
    t_drain();
    t_oe();
    t_irq();
    t_bank_b();
    t_bank_reset();
    print_verdict();
  end
endmodule
